// file: include/motion_pkg.sv
package motion_pkg;

  // clock and time units
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned FALL_UNIT_US  = 5000;
  localparam int unsigned STILL_UNIT_S  = 1;
  localparam int unsigned RATE_TOP_HZ   = 3200;
  localparam int unsigned WAKE_TOP_HZ   = 8;
  localparam int unsigned FALL_CYCLES   = CLK_HZ / 1_000_000 * FALL_UNIT_US;
  localparam int unsigned STILL_CYCLES  = CLK_HZ * STILL_UNIT_S;
  localparam int unsigned RATE_CYCLES   = CLK_HZ / RATE_TOP_HZ;
  localparam int unsigned WAKE_CYCLES   = CLK_HZ / WAKE_TOP_HZ;
  localparam logic [3:0]  RATE_MAX_CODE = 4'hf;

  // register offsets
  localparam logic [5:0] A_TAP_LEVEL  = 6'h1d;
  localparam logic [5:0] A_ACT_LEVEL  = 6'h24;
  localparam logic [5:0] A_STILL_LVL  = 6'h25;
  localparam logic [5:0] A_STILL_DUR  = 6'h26;
  localparam logic [5:0] A_AXIS_CFG   = 6'h27;
  localparam logic [5:0] A_FALL_THR   = 6'h28;
  localparam logic [5:0] A_FALL_DUR   = 6'h29;
  localparam logic [5:0] A_TAP_AXES   = 6'h2a;
  localparam logic [5:0] A_SRC_FLAGS  = 6'h2b;
  localparam logic [5:0] A_BW_CFG     = 6'h2c;
  localparam logic [5:0] A_PWR_CFG    = 6'h2d;

  // writable masks and reset values
  localparam logic [7:0] TAP_AXES_MASK = 8'h0f;
  localparam logic [7:0] BW_MASK       = 8'h1f;
  localparam logic [7:0] PWR_MASK      = 8'h3f;
  localparam logic [7:0] BW_RESET      = 8'h0a;
  localparam logic [7:0] ZERO_RESET    = 8'h00;

  // field positions
  localparam int ACT_COUPLE_BIT   = 7;
  localparam int STILL_COUPLE_BIT = 3;
  localparam int TAP_SUPPRESS_BIT = 3;
  localparam int ASLEEP_BIT       = 3;
  localparam int LOW_POWER_BIT    = 4;
  localparam int LINK_BIT         = 5;
  localparam int AUTO_SLEEP_BIT   = 4;
  localparam int MEASURE_BIT      = 3;
  localparam int SLEEP_BIT        = 2;

  // threshold lsb is 16 sample lsbs
  localparam int THR_SHIFT = 4;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } accel_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic {PHASE_STILL, PHASE_ACT} phase_t;

endpackage : motion_pkg

// file: design/motion_event_power_control.sv
// What this block does
// [RULE1] coupling bit 0 compares magnitude, 1 compares against a reference
// [RULE2] ac activity latches start reference, fires on larger difference
// [RULE3] ac stillness reloads reference on exceed, fires after quiet duration
// [RULE4] axis enable 1 joins detection; no axes enabled disables function
// [RULE5] activity fires when any enabled axis exceeds activity level
// [RULE6] stillness needs every enabled axis below level for whole duration
// [RULE7] fall threshold is eight bits at 62.5 mg, checked on all axes
// [RULE8] fall event after all axes low for fall_duration times 5 ms
// [RULE9] host avoids zero fall settings; threshold 0x05-0x09, time 0x14-0x46
// [RULE10] tap axis register: upper zeros, suppress at D3, axis enables D2-D0
// [RULE11] source bits show axes of latest event, overwritten not cleared
// [RULE12] a removed axis loses its source bit at the next event
// [RULE13] host reads source flags before clearing the interrupt
// [RULE14] asleep flag at D3, set only while auto sleep is configured, cleared whenever it is not
// [RULE15] rate register: zeros above, low power D4, rate D3-D0, reset 0x0a
// [RULE16] low power bit 0 normal, 1 reduced power with more noise
// [RULE17] host picks a rate its serial link can keep up with
// [RULE18] link bit chains activity after stillness; cleared means concurrent
// [RULE19] linked auto sleep sleeps on stillness, wakes on activity
// [RULE20] measure bit 0 standby, 1 measure; standby after power up
// [RULE21] sleep mutes data ready and fifo, keeps only activity, wakeup rate
// [RULE22] host goes standby then measure when clearing link or sleep bits
// [RULE23] wakeup code 0..3 gives 8, 4, 2, 1 Hz sleep sampling
// [RULE24] axis cfg: act coupling D7, act axes D6-D4, still D3, D2-D0
// [RULE25] detection and timers advance on sample tick and unit ticks
module motion_event_power_control
  import motion_pkg::*;
#(
  parameter int unsigned RATE_TOP_CYC  = RATE_CYCLES,
  parameter int unsigned WAKE_TOP_CYC  = WAKE_CYCLES,
  parameter int unsigned FALL_UNIT_CYC = FALL_CYCLES,
  parameter int unsigned STILL_UNIT_CYC = STILL_CYCLES
) (
  input  wire logic     i_clk_sys,      // system clock
  input  wire logic     i_arst_n,       // async reset, active low
  input  wire reg_req_t i_reg,          // register request
  output logic [7:0]    o_reg_rdata,    // read data, one cycle after rd
  input  wire accel_t   i_accel,        // current acceleration
  input  wire logic     i_tap_event,    // tap event pulse
  input  wire logic [2:0] i_tap_axes,   // first axes of that tap
  output logic          o_sample_tick,  // sample strobe
  output logic          o_act_event,    // activity pulse
  output logic          o_still_event,  // stillness pulse
  output logic          o_fall_event,   // free-fall pulse
  output logic          o_asleep,       // asleep flag, set by auto sleep only
  output logic          o_measuring,    // measure mode
  output logic          o_low_power,    // reduced power select
  output logic          o_ready_en,     // data ready allowed
  output logic          o_fifo_wr_en,   // fifo writes allowed
  output logic [2:0]    o_tap_axis_en,  // tap axes to tap engine
  output logic          o_tap_suppress, // double tap suppress
  output logic [7:0]    o_tap_level     // tap level to tap engine
);

  ////////////////////////////////////////////////////////////////////////
  logic       rst_q1, rst_n;
  logic [7:0] activity_level, stillness_level, stillness_duration;
  logic [7:0] motion_axis_cfg, fall_threshold, fall_duration;
  logic [7:0] tap_axis_select, bandwidth_power_cfg, power_mode_cfg;
  logic [7:0] tap_level;
  logic [2:0] activity_axis_hit, tap_axis_hit;
  logic       asleep;
  phase_t     phase;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tap_level           <= ZERO_RESET;
      activity_level      <= ZERO_RESET;
      stillness_level     <= ZERO_RESET;
      stillness_duration  <= ZERO_RESET;
      motion_axis_cfg     <= ZERO_RESET;
      fall_threshold      <= ZERO_RESET;
      fall_duration       <= ZERO_RESET;
      tap_axis_select     <= ZERO_RESET;
      bandwidth_power_cfg <= BW_RESET;                    // see [RULE15]
      power_mode_cfg      <= ZERO_RESET;                  // see [RULE20]
    end else if (i_reg.wr) begin
      unique case (i_reg.addr)
        A_TAP_LEVEL: tap_level          <= i_reg.wdata;
        A_ACT_LEVEL: activity_level     <= i_reg.wdata;
        A_STILL_LVL: stillness_level    <= i_reg.wdata;
        A_STILL_DUR: stillness_duration <= i_reg.wdata;
        A_AXIS_CFG:  motion_axis_cfg    <= i_reg.wdata;  // see [RULE24]
        A_FALL_THR:  fall_threshold     <= i_reg.wdata;  // see [RULE7]
        A_FALL_DUR:  fall_duration      <= i_reg.wdata;  // see [RULE8]
        A_TAP_AXES:
          tap_axis_select <= i_reg.wdata & TAP_AXES_MASK; // see [RULE10]
        A_BW_CFG:
          bandwidth_power_cfg <= i_reg.wdata & BW_MASK;   // see [RULE15]
        A_PWR_CFG:   power_mode_cfg <= i_reg.wdata & PWR_MASK;
        default: ;
      endcase
    end
  end

  logic [7:0] src_flags, next_rdata;
  assign src_flags = {1'b0, activity_axis_hit, asleep, tap_axis_hit};

  always_comb begin
    unique case (i_reg.addr)
      A_TAP_LEVEL: next_rdata = tap_level;
      A_ACT_LEVEL: next_rdata = activity_level;
      A_STILL_LVL: next_rdata = stillness_level;
      A_STILL_DUR: next_rdata = stillness_duration;
      A_AXIS_CFG:  next_rdata = motion_axis_cfg;
      A_FALL_THR:  next_rdata = fall_threshold;
      A_FALL_DUR:  next_rdata = fall_duration;
      A_TAP_AXES:  next_rdata = tap_axis_select;
      A_SRC_FLAGS: next_rdata = src_flags;              // see [RULE14]
      A_BW_CFG:    next_rdata = bandwidth_power_cfg;
      A_PWR_CFG:   next_rdata = power_mode_cfg;
      default:     next_rdata = ZERO_RESET;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) o_reg_rdata <= ZERO_RESET;
    else if (i_reg.rd) o_reg_rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  logic [2:0] activity_axis_en, stillness_axis_en;
  logic       activity_coupling, stillness_coupling;
  logic       act_on, still_on, link_on, auto_on, measuring, sleeping;
  logic       act_run, still_run, fall_run;

  assign activity_coupling  = motion_axis_cfg[ACT_COUPLE_BIT];
  assign stillness_coupling = motion_axis_cfg[STILL_COUPLE_BIT];
  assign activity_axis_en   = motion_axis_cfg[6:4];
  assign stillness_axis_en  = motion_axis_cfg[2:0];
  assign act_on    = |activity_axis_en;                    // see [RULE4]
  assign still_on  = |stillness_axis_en;                   // see [RULE4]
  assign link_on   = power_mode_cfg[LINK_BIT] & act_on & still_on;
  assign auto_on   = link_on & power_mode_cfg[AUTO_SLEEP_BIT];
  assign measuring = power_mode_cfg[MEASURE_BIT];          // see [RULE20]
  assign sleeping  = power_mode_cfg[SLEEP_BIT] | asleep;
  assign act_run   = measuring & act_on
                   & (!link_on | phase == PHASE_ACT);      // see [RULE18]
  assign still_run = measuring & still_on & !sleeping
                   & (!link_on | phase == PHASE_STILL);    // see [RULE21]
  assign fall_run  = measuring & !sleeping;                // see [RULE21]

  ////////////////////////////////////////////////////////////////////////
  // sample and unit tick dividers
  logic [31:0] period, smp_cnt, fall_cnt_clk, still_cnt_clk;
  logic        fall_tick, sec_tick;

  always_comb begin
    if (sleeping)                                          // see [RULE23]
      period = 32'(WAKE_TOP_CYC) << power_mode_cfg[1:0];
    else
      period = 32'(RATE_TOP_CYC) << (RATE_MAX_CODE - bandwidth_power_cfg[3:0]);
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt       <= '0;
      o_sample_tick <= 1'b0;
    end else begin
      o_sample_tick <= 1'b0;
      if (!measuring) smp_cnt <= '0;
      else if (smp_cnt >= period - 32'd1) begin           // see [RULE25]
        smp_cnt       <= '0;
        o_sample_tick <= 1'b1;
      end else smp_cnt <= smp_cnt + 32'd1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt_clk  <= '0;
      still_cnt_clk <= '0;
    end else begin
      fall_cnt_clk  <= (!measuring || fall_tick) ? '0 : fall_cnt_clk + 32'd1;
      still_cnt_clk <= (!measuring || sec_tick) ? '0 : still_cnt_clk + 32'd1;
    end
  end
  assign fall_tick = fall_cnt_clk == 32'(FALL_UNIT_CYC) - 32'd1;
  assign sec_tick  = still_cnt_clk == 32'(STILL_UNIT_CYC) - 32'd1;

  ////////////////////////////////////////////////////////////////////////
  // per-axis comparisons
  function automatic logic [16:0] magn(input logic signed [16:0] v);
    magn = v[16] ? 17'(-v) : 17'(v);
  endfunction : magn

  function automatic logic [16:0] scale(input logic [7:0] t);
    scale = 17'(t) << THR_SHIFT;
  endfunction : scale

  logic signed [15:0] cur [3];
  logic signed [15:0] act_ref [3];
  logic signed [15:0] still_ref [3];
  logic [2:0] act_hit, still_over, fall_low;

  assign cur[0] = i_accel.x;
  assign cur[1] = i_accel.y;
  assign cur[2] = i_accel.z;

  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic [16:0] mag, act_d, still_d;
    assign mag     = magn(17'(cur[a]));
    assign act_d   = activity_coupling                    // see [RULE1]
                   ? magn(17'(cur[a]) - 17'(act_ref[a])) : mag;
    assign still_d = stillness_coupling
                   ? magn(17'(cur[a]) - 17'(still_ref[a])) : mag;
    assign act_hit[a]    = activity_axis_en[2-a]
                         & (act_d > scale(activity_level));
    assign still_over[a] = stillness_axis_en[2-a]
                         & (still_d >= scale(stillness_level));
    assign fall_low[a]   = mag < scale(fall_threshold);   // see [RULE7]
  end

  ////////////////////////////////////////////////////////////////////////
  // activity
  logic act_armed, act_fire;
  assign act_fire = act_run & o_sample_tick & (|act_hit)  // see [RULE5]
                  & (act_armed | !activity_coupling);     // see [RULE2]

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_armed <= 1'b0;
      act_ref   <= '{default: '0};
    end else if (!act_run || act_fire) act_armed <= 1'b0;
    else if (o_sample_tick && !act_armed) begin
      act_armed <= 1'b1;
      act_ref   <= cur;                                   // see [RULE2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stillness
  logic       still_armed, still_quiet, still_done, still_fire;
  logic [7:0] still_secs;
  assign still_fire = still_run & still_quiet & !still_done
                    & (still_secs >= stillness_duration); // see [RULE6]

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      still_armed <= 1'b0;
      still_quiet <= 1'b0;
      still_done  <= 1'b0;
      still_secs  <= '0;
      still_ref   <= '{default: '0};
    end else if (!still_run) begin
      still_armed <= 1'b0;
      still_quiet <= 1'b0;
      still_done  <= 1'b0;
      still_secs  <= '0;
    end else begin
      if (still_fire) still_done <= 1'b1;
      if (o_sample_tick) begin
        if (!still_armed || (|still_over)) begin          // see [RULE3]
          still_armed <= 1'b1;
          still_ref   <= cur;
        end
        still_quiet <= still_armed & ~|still_over;        // see [RULE6]
        if (!still_armed || (|still_over)) begin
          still_secs <= '0;
          still_done <= 1'b0;
        end
      end else if (sec_tick && still_quiet && still_secs != 8'hff)
        still_secs <= still_secs + 8'd1;                  // see [RULE25]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // free fall
  logic       fall_quiet, fall_done, fall_fire;
  logic [7:0] fall_units;
  assign fall_fire = fall_run & fall_quiet & !fall_done
                   & (fall_units >= fall_duration);       // see [RULE8]

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fall_quiet <= 1'b0;
      fall_done  <= 1'b0;
      fall_units <= '0;
    end else if (!fall_run) begin
      fall_quiet <= 1'b0;
      fall_done  <= 1'b0;
      fall_units <= '0;
    end else begin
      if (fall_fire) fall_done <= 1'b1;
      if (o_sample_tick) begin
        fall_quiet <= &fall_low;                          // see [RULE7]
        if (!(&fall_low)) begin
          fall_units <= '0;
          fall_done  <= 1'b0;
        end
      end else if (fall_tick && fall_quiet && fall_units != 8'hff)
        fall_units <= fall_units + 8'd1;                  // see [RULE8]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link phase, auto sleep, source flags
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) phase <= PHASE_STILL;
    else if (!link_on || !measuring) phase <= PHASE_STILL;
    else if (still_fire) phase <= PHASE_ACT;              // see [RULE18]
    else if (act_fire) phase <= PHASE_STILL;              // see [RULE18]
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) asleep <= 1'b0;
    else if (!auto_on) asleep <= 1'b0;                    // see [RULE14]
    else if (still_fire) asleep <= 1'b1;                  // see [RULE19]
    else if (act_fire) asleep <= 1'b0;                    // see [RULE19]
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      activity_axis_hit <= '0;
      tap_axis_hit      <= '0;
    end else begin
      if (act_fire)                                       // see [RULE11]
        activity_axis_hit <= {act_hit[0], act_hit[1],     // see [RULE12]
                              act_hit[2]};
      if (i_tap_event)                                    // see [RULE11]
        tap_axis_hit <= i_tap_axes & tap_axis_select[2:0]; // see [RULE12]
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_act_event   <= 1'b0;
      o_still_event <= 1'b0;
      o_fall_event  <= 1'b0;
    end else begin
      o_act_event   <= act_fire;
      o_still_event <= still_fire;
      o_fall_event  <= fall_fire;
    end
  end

  assign o_asleep       = asleep;
  assign o_measuring    = measuring;
  assign o_low_power    = bandwidth_power_cfg[LOW_POWER_BIT]; // see [RULE16]
  assign o_ready_en     = measuring & !sleeping;          // see [RULE21]
  assign o_fifo_wr_en   = measuring & !sleeping;          // see [RULE21]
  assign o_tap_axis_en  = tap_axis_select[2:0];           // see [RULE10]
  assign o_tap_suppress = tap_axis_select[TAP_SUPPRESS_BIT];
  assign o_tap_level    = tap_level;

endmodule : motion_event_power_control

// file: verif/motion_checker.sv
module motion_checker
  import motion_pkg::*;
(
  input wire logic       i_clk_sys,     // clock
  input wire logic       i_arst_n,      // reset
  input wire reg_req_t   i_reg,         // request
  input wire logic [7:0] o_reg_rdata,   // read data
  input wire logic       o_sample_tick, // tick
  input wire logic       o_act_event,   // activity
  input wire logic       o_still_event, // stillness
  input wire logic       o_fall_event,  // fall
  input wire logic       o_asleep,      // asleep
  input wire logic       o_measuring,   // measure
  input wire logic       o_low_power,   // low power
  input wire logic       o_ready_en,    // ready
  input wire logic       o_fifo_wr_en   // fifo
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);
  logic wr_pwr;
  logic wr_bw;
  logic rd_bw;
  logic rd_src;
  logic any_ev;
  assign wr_pwr = i_reg.wr && i_reg.addr == A_PWR_CFG;
  assign wr_bw  = i_reg.wr && i_reg.addr == A_BW_CFG;
  assign rd_bw  = i_reg.rd && !i_reg.wr && i_reg.addr == A_BW_CFG;
  assign rd_src = i_reg.rd && i_reg.addr == A_SRC_FLAGS;
  assign any_ev = o_act_event || o_still_event || o_fall_event;
  ////////////////////////////////////////////////////////////////////////
  meas_follow_a: assert property (wr_pwr |=>
    o_measuring == $past(i_reg.wdata[MEASURE_BIT]))
    else $error("measure bit not applied");
  low_power_a: assert property (wr_bw |=>
    o_low_power == $past(i_reg.wdata[LOW_POWER_BIT]))
    else $error("low power bit not applied");
  ready_gate_a: assert property (
    (o_ready_en || o_fifo_wr_en) |->
    o_measuring && !o_asleep && o_ready_en == o_fifo_wr_en)
    else $error("ready or fifo enabled while not allowed");
  standby_quiet_a: assert property (!o_measuring &&
    !$past(o_measuring) |-> !any_ev) else $error("event in standby");
  act_on_tick_a: assert property (o_act_event |->
    $past(o_sample_tick)) else $error("activity without sample");
  tick_pulse_a: assert property (o_sample_tick |=>
    !o_sample_tick) else $error("sample tick too long");
  sleep_cause_a: assert property ($rose(o_asleep) |->
    o_still_event || $past(o_still_event)) else $error("sleep without cause");
  rate_read_a: assert property (rd_bw |=>
    o_reg_rdata[7:5] == 3'h0 && o_reg_rdata[4] == o_low_power)
    else $error("rate register readback");
  asleep_read_a: assert property (rd_src |=>
    !o_reg_rdata[7] && o_reg_rdata[ASLEEP_BIT] == $past(o_asleep))
    else $error("asleep flag read");
  cover property (o_act_event);
  cover property (o_still_event);
  cover property (o_fall_event);
  cover property ($rose(o_asleep));
endmodule : motion_checker

bind motion_event_power_control motion_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg(i_reg),
  .o_reg_rdata(o_reg_rdata), .o_sample_tick(o_sample_tick),
  .o_act_event(o_act_event), .o_still_event(o_still_event),
  .o_fall_event(o_fall_event), .o_asleep(o_asleep),
  .o_measuring(o_measuring), .o_low_power(o_low_power),
  .o_ready_en(o_ready_en), .o_fifo_wr_en(o_fifo_wr_en)
);

// file: verif/host_model.sv
module host_model
  import motion_pkg::*;
(
  input  wire logic       i_clk_sys,   // clock
  input  wire logic [7:0] i_reg_rdata, // read data
  output reg_req_t        o_reg        // register request
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_reg = '0;
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    o_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge i_clk_sys);
    o_reg <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    o_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk_sys);
    o_reg <= '0;
    #1;
    v = i_reg_rdata;
  endtask : rd
  // standby first, then the new mode in a later write
  task automatic set_mode(input logic [7:0] v);
    wr(A_PWR_CFG, 8'h00);
    wr(A_PWR_CFG, v);
  endtask : set_mode
  // source flags are read before anything else is done
  task automatic src(output logic [7:0] v);
    rd(A_SRC_FLAGS, v);
  endtask : src
endmodule : host_model

// file: verif/tb_top.sv
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_top
  import motion_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clk_sys = 1'b0;
  logic       i_arst_n  = 1'b0;
  reg_req_t   req;
  logic [7:0] rdata;
  accel_t     accel     = '0;
  logic       tap_ev    = 1'b0;
  logic [2:0] tap_ax    = 3'h0;
  logic       act_ev, still_ev, fall_ev, asleep, rdy, fifo_en, lowp;
  logic       tick, meas, supp;
  logic [2:0] tap_en;
  logic [7:0] tap_lvl;
  logic [7:0] d;
  logic       got;
  int         err_count  = 0;
  int         n_compared = 0;
  logic [5:0] ra[8] = '{A_FALL_THR, A_FALL_DUR, A_TAP_AXES, A_SRC_FLAGS,
                        A_BW_CFG, A_PWR_CFG, A_AXIS_CFG, 6'h3f};
  logic [7:0] re[8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                        8'h0a, 8'h00, 8'h00, 8'h00};
  logic [5:0] wa[5] = '{A_TAP_AXES, A_BW_CFG, A_PWR_CFG, A_SRC_FLAGS,
                        A_TAP_LEVEL};
  logic [7:0] we[5] = '{8'h0f, 8'h1f, 8'h3f, 8'h00, 8'hff};

  always #5 i_clk_sys = ~i_clk_sys;

  motion_event_power_control #(
    .RATE_TOP_CYC(4), .WAKE_TOP_CYC(16), .FALL_UNIT_CYC(3),
    .STILL_UNIT_CYC(5)
  ) DUT (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg(req),
    .o_reg_rdata(rdata), .i_accel(accel), .i_tap_event(tap_ev),
    .i_tap_axes(tap_ax), .o_sample_tick(tick), .o_act_event(act_ev),
    .o_still_event(still_ev), .o_fall_event(fall_ev), .o_asleep(asleep),
    .o_measuring(meas), .o_low_power(lowp), .o_ready_en(rdy),
    .o_fifo_wr_en(fifo_en), .o_tap_axis_en(tap_en),
    .o_tap_suppress(supp), .o_tap_level(tap_lvl)
  );
  host_model host (.i_clk_sys(i_clk_sys), .i_reg_rdata(rdata), .o_reg(req));
  ////////////////////////////////////////////////////////////////////////
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    host.rd(a, d);
    `CHK("register", e, d)
  endtask : rd_chk
  task automatic src_chk(input logic [7:0] e);
    host.src(d);
    `CHK("source flags", e, d)
  endtask : src_chk
  task automatic set_acc(input logic signed [15:0] x, y, z);
    @(posedge i_clk_sys);
    accel <= '{x: x, y: y, z: z};
  endtask : set_acc
  task automatic tap(input logic [2:0] ax);
    @(posedge i_clk_sys);
    tap_ev <= 1'b1;
    tap_ax <= ax;
    @(posedge i_clk_sys);
    tap_ev <= 1'b0;
  endtask : tap
  // waits up to n cycles for an event in mask {fall, still, act}
  task automatic wait_ev(input int n, input logic [2:0] m, input logic e);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(posedge i_clk_sys);
      #1;
      if (({fall_ev, still_ev, act_ev} & m) != 3'h0) got = 1'b1;
    end
    `CHK("event seen", e, got)
  endtask : wait_ev
  // cycles between two sample ticks
  task automatic tick_gap(input int e);
    int n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
    end while (!tick);
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (!tick);
    `CHK("tick period", e, n)
  endtask : tick_gap
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    `CHK("standby", 1'b0, meas)
    foreach (ra[i]) rd_chk(ra[i], re[i]);
    foreach (wa[i]) begin
      host.wr(wa[i], 8'hff);
      rd_chk(wa[i], we[i]);
    end
    `CHK("tap axes", 3'h7, tap_en)
    `CHK("tap suppress", 1'b1, supp)
    `CHK("tap level", 8'hff, tap_lvl)
    `CHK("low power", 1'b1, lowp)
    `CHK("ready in sleep", 1'b0, rdy)
    `CHK("fifo in sleep", 1'b0, fifo_en)
    host.set_mode(8'h08);
    host.wr(A_BW_CFG, 8'h0a);
    `CHK("measuring", 1'b1, meas)
    `CHK("ready awake", 1'b1, rdy)
    `CHK("fifo awake", 1'b1, fifo_en)
    `CHK("normal power", 1'b0, lowp)
    tick_gap(128);
    host.wr(A_TAP_AXES, 8'h05);
    `CHK("no suppress", 1'b0, supp)
    tap(3'h7);
    src_chk(8'h05);
    host.wr(A_TAP_AXES, 8'h01);
    src_chk(8'h05);
    tap(3'h7);
    src_chk(8'h01);
    host.wr(A_ACT_LEVEL, 8'h02);
    host.wr(A_AXIS_CFG, 8'h60);
    set_acc(0, 1000, 0);
    wait_ev(300, 3'b001, 1'b1);
    src_chk(8'h21);
    host.wr(A_AXIS_CFG, 8'h40);
    wait_ev(300, 3'b001, 1'b0);
    src_chk(8'h21);
    set_acc(-33, 1000, 0);
    wait_ev(300, 3'b001, 1'b1);
    src_chk(8'h41);
    host.wr(A_PWR_CFG, 8'h00);
    host.wr(A_AXIS_CFG, 8'hc0);
    set_acc(1000, 0, 0);
    host.wr(A_PWR_CFG, 8'h08);
    wait_ev(400, 3'b001, 1'b0);
    set_acc(1033, 0, 0);
    wait_ev(300, 3'b001, 1'b1);
    host.wr(A_PWR_CFG, 8'h00);
    host.wr(A_AXIS_CFG, 8'h44);
    host.wr(A_STILL_LVL, 8'h02);
    host.wr(A_STILL_DUR, 8'h01);
    set_acc(100, 0, 0);
    host.wr(A_PWR_CFG, 8'h38);
    wait_ev(400, 3'b011, 1'b0);
    set_acc(0, 0, 0);
    wait_ev(600, 3'b010, 1'b1);
    @(posedge i_clk_sys);
    #1;
    `CHK("asleep", 1'b1, asleep)
    src_chk(8'h49);
    `CHK("ready asleep", 1'b0, rdy)
    tick_gap(16);
    set_acc(100, 0, 0);
    wait_ev(600, 3'b001, 1'b1);
    @(posedge i_clk_sys);
    #1;
    `CHK("awake", 1'b0, asleep)
    host.set_mode(8'h00);
    host.wr(A_AXIS_CFG, 8'h00);
    host.wr(A_FALL_THR, 8'h05);
    host.wr(A_FALL_DUR, 8'h14);
    host.wr(A_PWR_CFG, 8'h08);
    wait_ev(400, 3'b100, 1'b0);
    set_acc(0, 0, 79);
    wait_ev(40, 3'b100, 1'b0);
    wait_ev(400, 3'b100, 1'b1);
    finish_test();
  end
endmodule : tb_top
